// File: bench/tw_master_sva.sv
`timescale 1ns/1ns
module tw_master_sva #(
	parameter [15:0] QUARTER_CYC = 16'h0004,
	parameter EVT_W = 8
) (
	// clock, reset
	input wire I_CLK_SYS,
	input wire I_RST,
	// software side
	input wire I_CTRL_WR,
	input wire [7:0] I_CTRL_WDATA,
	input wire I_DATA_WR,
	input wire I_EVT_READY,
	// watched outputs
	input wire O_SCL_OUT,
	input wire O_SCL_OE,
	input wire O_SDA_OUT,
	input wire O_SDA_OE,
	input wire [7:0] O_CTRL,
	input wire [7:0] O_STATUS,
	input wire [7:0] O_DATA,
	input wire O_BUS_BUSY,
	input wire O_EVT_VALID,
	input wire [EVT_W-1:0] O_EVT_CODE
);
	localparam int Q2 = 2 * QUARTER_CYC;
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RST);
	// -------------------------------------------
	// start condition steps
	// -------------------------------------------
	sequence start_cond;
		$rose(O_SDA_OE) && !O_SCL_OE;
	endsequence
	sequence clock_pulled;
		O_SDA_OE throughout (##[1:Q2] O_SCL_OE);
	endsequence
	reset_state_a: assert property (disable iff (1'b0) I_RST |=> O_STATUS == 8'hf8 && O_DATA == 8'hff
		&& !O_SCL_OE && !O_SDA_OE && !O_EVT_VALID) else $error("reset state wrong");
	start_shape_a: assert property (start_cond |-> clock_pulled) else $error("start shape wrong");
	low_drive_a: assert property (!O_SCL_OUT && !O_SDA_OUT) else $error("pin level not low");
	status_mask_a: assert property (O_STATUS[2:0] == 3'h0) else $error("status low bits set");
	flag_code_a: assert property ($rose(O_CTRL[7]) |-> O_EVT_VALID && O_STATUS inside {8'h08, 8'h10, 8'h18,
		8'h20, 8'h28, 8'h30, 8'h38, 8'h40, 8'h48}) else $error("flag without code");
	flag_hold_a: assert property (O_CTRL[7] && !I_CTRL_WR |=> O_CTRL[7]) else $error("flag dropped");
	bus_frozen_a: assert property (O_CTRL[7] && !I_CTRL_WR |=> $stable(O_SDA_OE) && $stable(O_SCL_OE))
		else $error("bus moved while suspended");
	clock_low_a: assert property (O_CTRL[7] && O_BUS_BUSY && O_STATUS != 8'h38 |-> O_SCL_OE)
		else $error("clock released with flag");
	collision_a: assert property (I_DATA_WR && !I_CTRL_WR && !O_CTRL[7] |=> O_CTRL[3]
		&& O_DATA == $past(O_DATA)) else $error("collision missed");
	stop_flag_a: assert property ($fell(O_BUS_BUSY) |-> !O_CTRL[7]) else $error("flag after stop");
	event_hold_a: assert property (O_EVT_VALID && !I_EVT_READY |=> O_EVT_VALID && $stable(O_EVT_CODE))
		else $error("event lost");
endmodule // tw_master_sva
bind two_wire_master_transmitter tw_master_sva #(.QUARTER_CYC(QUARTER_CYC), .EVT_W(EVT_W)) i_sva (
	.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_CTRL_WR(I_CTRL_WR), .I_CTRL_WDATA(I_CTRL_WDATA),
	.I_DATA_WR(I_DATA_WR), .I_EVT_READY(I_EVT_READY), .O_SCL_OUT(O_SCL_OUT), .O_SCL_OE(O_SCL_OE),
	.O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE), .O_CTRL(O_CTRL), .O_STATUS(O_STATUS), .O_DATA(O_DATA),
	.O_BUS_BUSY(O_BUS_BUSY), .O_EVT_VALID(O_EVT_VALID), .O_EVT_CODE(O_EVT_CODE));

// File: bench/tw_slave_rx.sv
`timescale 1ns/1ns
module tw_slave_rx (
	// wire levels
	input wire scl,
	input wire sda,
	input wire ack,
	// pull-down and captured byte
	output reg sda_oe,
	output reg [7:0] last_byte
);
	reg [7:0] sh;
	integer cnt;
	initial begin
		sda_oe = 0;
		cnt = 0;
		sh = 0;
		last_byte = 0;
	end
	// start condition restarts the bit count
	always @(negedge sda) if (scl) cnt = 0;
	// msb first, eight bits a byte
	always @(posedge scl) begin
		if (cnt < 8) sh = {sh[6:0], sda};
		cnt = cnt + 1;
		if (cnt == 8) last_byte = sh;
	end
	// acknowledge is a low level through the ninth clock
	always @(negedge scl) begin
		if (cnt == 8) sda_oe = ack;
		else if (cnt == 9) begin
			sda_oe = 0;
			cnt = 0;
		end
	end
endmodule // tw_slave_rx

// File: bench/two_wire_master_transmitter_bench.sv
`timescale 1ns/1ns
`include "two_wire_master_defines.vh"
module two_wire_master_transmitter_bench;
	reg clk = 0, rst = 1, cwr = 0, dwr = 0, rdy = 0, ack = 1;
	reg [7:0] cd = 0, dd = 0;
	wire scl_oe, sda_oe, s_oe, busy, rx, ev_v;
	wire [7:0] ctrl, st, dat, ev_c, s_byte;
	wire scl_w = ~scl_oe;
	wire sda_w = ~(sda_oe | s_oe);
	integer error_cnt = 0, comparisons = 0;
	initial forever #5 clk = ~clk;
	two_wire_master_transmitter #(.QUARTER_CYC(16'h0004)) i_dut (.I_CLK_SYS(clk), .I_RST(rst), .I_CE(1'b1),
		.I_SCL(scl_w), .I_SDA(sda_w), .O_SCL_OUT(), .O_SCL_OE(scl_oe), .O_SDA_OUT(), .O_SDA_OE(sda_oe),
		.I_CTRL_WR(cwr), .I_CTRL_WDATA(cd), .I_DATA_WR(dwr), .I_DATA_WDATA(dd), .O_CTRL(ctrl),
		.O_STATUS(st), .O_DATA(dat), .O_MASTER_RX(rx), .O_BUS_BUSY(busy), .O_EVT_VALID(ev_v),
		.O_EVT_CODE(ev_c), .I_EVT_READY(rdy));
	tw_slave_rx i_slave (.scl(scl_w), .sda(sda_w), .ack(ack), .sda_oe(s_oe), .last_byte(s_byte));
	task chk(input [7:0] got, input [7:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task conclude;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
			if (error_cnt == 0 && comparisons > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task cw(input [7:0] v);
		begin
			cd = v;
			cwr = 1;
			@(negedge clk);
			cwr = 0;
		end
	endtask
	task dw(input [7:0] v);
		begin
			dd = v;
			dwr = 1;
			@(negedge clk);
			dwr = 0;
		end
	endtask
	task wflag;
		integer n;
		begin
			n = 0;
			while (ctrl[7] !== 1'b1 && n < 3000) begin
				@(negedge clk);
				n = n + 1;
			end
			if (n == 3000) chk(8'h00, 8'h01);
		end
	endtask
	task pop(input [7:0] exp);
		begin
			chk({7'h00, ev_v}, 8'h01);
			chk(ev_c, exp);
			rdy = 1;
			@(negedge clk);
			rdy = 0;
		end
	endtask
	task step(input [7:0] c, input [7:0] exp);
		begin
			cw(c);
			wflag;
			chk(st & 8'hf8, exp);
			pop(exp);
		end
	endtask
	initial begin
		#200000;
		error_cnt = error_cnt + 1;
		conclude;
	end
	initial begin
		repeat (4) @(negedge clk);
		rst = 0;
		chk(st, `ST_IDLE_CODE);
		chk(dat, 8'hff);
		chk(ctrl, 8'h00);
		dw(8'h33);
		chk(ctrl, 8'h08);
		chk(dat, 8'hff);
		$display("test reset done");
		cw(8'ha4);
		wflag;
		chk(st, `ST_START_SENT);
		dw(8'ha0);
		chk(ctrl, 8'ha4);
		cw(8'h84);
		wflag;
		chk(st, `ST_ADDR_ACK);
		chk(s_byte, 8'ha0);
		// two codes unread: the next report must wait
		dw(8'h3c);
		cw(8'h84);
		repeat (300) @(negedge clk);
		chk(ctrl, 8'h04);
		pop(`ST_START_SENT);
		pop(`ST_ADDR_ACK);
		wflag;
		chk(st, `ST_DATA_ACK);
		chk(s_byte, 8'h3c);
		pop(`ST_DATA_ACK);
		ack = 0;
		dw(8'hc3);
		step(8'h84, `ST_DATA_NACK);
		ack = 1;
		$display("test write done");
		step(8'ha4, `ST_RSTART_SENT);
		chk(busy, 8'h01);
		dw(8'ha1);
		step(8'h84, `ST_RD_ACK);
		chk(rx, 8'h01);
		cw(8'h94);
		repeat (100) @(negedge clk);
		chk(ctrl, 8'h04);
		chk({busy, rx, ev_v}, 8'h00);
		$display("test restart done");
		cw(8'ha4);
		wflag;
		pop(`ST_START_SENT);
		ack = 0;
		dw(8'ha2);
		step(8'h84, `ST_ADDR_NACK);
		ack = 1;
		step(8'hb4, `ST_START_SENT);
		chk(ctrl, 8'ha4);
		cw(8'h94);
		repeat (100) @(negedge clk);
		chk(busy, 8'h00);
		$display("test stop start done");
		conclude;
	end
endmodule // two_wire_master_transmitter_bench

// File: hdl/two_wire_master_defines.vh
`ifndef TWO_WIRE_MASTER_DEFINES_VH
`define TWO_WIRE_MASTER_DEFINES_VH

// ----------------------------------------------------------------------
// control_reg field positions
// ----------------------------------------------------------------------
`define CTRL_FLAG 7
`define CTRL_ACK_EN 6
`define CTRL_START 5
`define CTRL_STOP 4
`define CTRL_WC 3
`define CTRL_ENABLE 2
`define CTRL_RESET 8'h00

// ----------------------------------------------------------------------
// status codes, prescaler bits read as zero
// ----------------------------------------------------------------------
`define ST_IDLE_CODE 8'hf8
`define ST_START_SENT 8'h08
`define ST_RSTART_SENT 8'h10
`define ST_ADDR_ACK 8'h18
`define ST_ADDR_NACK 8'h20
`define ST_DATA_ACK 8'h28
`define ST_DATA_NACK 8'h30
`define ST_ARB_LOST 8'h38
`define ST_RD_ACK 8'h40
`define ST_RD_NACK 8'h48

// ----------------------------------------------------------------------
// bus timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define QUARTER_NS 2500
`define QUARTER_CYC (`QUARTER_NS / `CLK_PERIOD_NS)
`define BYTE_LAST_BIT 4'h8
`define DATA_RESET 8'hff

`endif

// File: hdl/two_wire_master_transmitter.v
`timescale 1ns/1ns
`include "two_wire_master_defines.vh"

module two_wire_master_transmitter #(
	parameter [15:0] QUARTER_CYC = `QUARTER_CYC,
	parameter EVT_W = 8,
	parameter EVT_DEPTH = 2
) (
	// clock, reset, enable
	input wire I_CLK_SYS,
	input wire I_RST,
	input wire I_CE,
	// two-wire bus pins
	input wire I_SCL,
	input wire I_SDA,
	output reg O_SCL_OUT,
	output reg O_SCL_OE,
	output reg O_SDA_OUT,
	output reg O_SDA_OE,
	// software access
	input wire I_CTRL_WR,
	input wire [7:0] I_CTRL_WDATA,
	input wire I_DATA_WR,
	input wire [7:0] I_DATA_WDATA,
	output reg [7:0] O_CTRL,
	output reg [7:0] O_STATUS,
	output reg [7:0] O_DATA,
	output reg O_MASTER_RX,
	output reg O_BUS_BUSY,
	// status event stream
	output wire O_EVT_VALID,
	output wire [EVT_W-1:0] O_EVT_CODE,
	input wire I_EVT_READY
);

	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_WAIT_FREE = 3'h1;
	localparam [2:0] S_START = 3'h2;
	localparam [2:0] S_BIT = 3'h3;
	localparam [2:0] S_STOP = 3'h4;
	localparam [2:0] S_REPORT = 3'h5;
	localparam [2:0] S_HOLD = 3'h6;

	// ------------------------------------------------------------------
	// pin synchronisers and bus state
	// ------------------------------------------------------------------
	reg scl_s1_reg;
	reg scl_s2_reg;
	reg sda_s1_reg;
	reg sda_s2_reg;
	reg sda_prev_reg;

	always @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			scl_s1_reg <= 1'b1;
			scl_s2_reg <= 1'b1;
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			O_BUS_BUSY <= 1'b0;
		end else if (I_CE) begin
			scl_s1_reg <= I_SCL;
			scl_s2_reg <= scl_s1_reg;
			sda_s1_reg <= I_SDA;
			sda_s2_reg <= sda_s1_reg;
			sda_prev_reg <= sda_s2_reg;
			// start seen: data falls while clock high; stop seen: data rises
			if (scl_s2_reg && sda_prev_reg && !sda_s2_reg)
				O_BUS_BUSY <= 1'b1;
			else if (scl_s2_reg && !sda_prev_reg && sda_s2_reg)
				O_BUS_BUSY <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// status event buffer, shift type so the head is a flip-flop
	// ------------------------------------------------------------------
	reg [EVT_W-1:0] evt_mem_reg [0:EVT_DEPTH-1];
	reg [EVT_DEPTH-1:0] evt_vld_reg;
	wire evt_pop;
	wire evt_push;
	wire evt_ready;
	wire [EVT_W-1:0] evt_din;
	wire [EVT_DEPTH:0] evt_shifted;
	// occupancy of the slot below each slot after the shift; below slot 0 counts as full
	wire [EVT_DEPTH:0] evt_below;

	assign evt_pop = evt_vld_reg[0] & I_EVT_READY;
	assign evt_ready = ~evt_vld_reg[EVT_DEPTH-1] | evt_pop;
	assign evt_shifted = evt_pop ? {2'b00, evt_vld_reg[EVT_DEPTH-1:1]} : {1'b0, evt_vld_reg};
	assign evt_below = {evt_shifted[EVT_DEPTH-1:0], 1'b1};
	assign O_EVT_VALID = evt_vld_reg[0];
	assign O_EVT_CODE = evt_mem_reg[0];

	genvar gi;
	generate
		for (gi = 0; gi < EVT_DEPTH; gi = gi + 1) begin : g_evt
			// slot takes the new code if it is the first free one after the shift
			wire take_new = evt_push && !evt_shifted[gi] && evt_below[gi];
			always @(posedge I_CLK_SYS) begin
				if (I_RST) begin
					evt_vld_reg[gi] <= 1'b0;
					evt_mem_reg[gi] <= {EVT_W{1'b0}};
				end else if (I_CE) begin
					if (take_new) begin
						evt_mem_reg[gi] <= evt_din;
						evt_vld_reg[gi] <= 1'b1;
					end else begin
						evt_vld_reg[gi] <= evt_shifted[gi];
						if (evt_pop && gi < EVT_DEPTH - 1)
							evt_mem_reg[gi] <= evt_mem_reg[(gi + 1) % EVT_DEPTH];
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// control, data and bus engine
	// ------------------------------------------------------------------
	reg [2:0] state_reg;
	reg [1:0] phase_reg;
	reg [15:0] qcnt_reg;
	reg [3:0] bitcnt_reg;
	reg [7:0] shift_reg;
	reg [7:0] code_reg;
	reg flag_reg;
	reg ack_en_reg;
	reg start_req_reg;
	reg stop_req_reg;
	reg wc_reg;
	reg enable_reg;
	reg owner_reg;
	reg rep_reg;
	reg first_reg;
	reg addr_rd_reg;
	reg ack_reg;
	wire tick;

	assign tick = (qcnt_reg == QUARTER_CYC - 16'h0001);
	assign evt_push = (state_reg == S_REPORT) && evt_ready;
	assign evt_din = code_reg[EVT_W-1:0];

	// pick the completion code after the ninth bit
	function [7:0] byte_code;
		input first;
		input rd;
		input ack;
		begin
			if (first && rd)
				byte_code = ack ? `ST_RD_ACK : `ST_RD_NACK;
			else if (first)
				byte_code = ack ? `ST_ADDR_ACK : `ST_ADDR_NACK;
			else
				byte_code = ack ? `ST_DATA_ACK : `ST_DATA_NACK;
		end
	endfunction

	always @* begin
		O_CTRL = 8'h00;
		O_CTRL[`CTRL_FLAG] = flag_reg;
		O_CTRL[`CTRL_ACK_EN] = ack_en_reg;
		O_CTRL[`CTRL_START] = start_req_reg;
		O_CTRL[`CTRL_STOP] = stop_req_reg;
		O_CTRL[`CTRL_WC] = wc_reg;
		O_CTRL[`CTRL_ENABLE] = enable_reg;
	end

	always @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			state_reg <= S_IDLE;
			phase_reg <= 2'h0;
			qcnt_reg <= 16'h0000;
			bitcnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			code_reg <= `ST_IDLE_CODE;
			flag_reg <= 1'b0;
			ack_en_reg <= 1'b0;
			start_req_reg <= 1'b0;
			stop_req_reg <= 1'b0;
			wc_reg <= 1'b0;
			enable_reg <= 1'b0;
			owner_reg <= 1'b0;
			rep_reg <= 1'b0;
			first_reg <= 1'b0;
			addr_rd_reg <= 1'b0;
			ack_reg <= 1'b0;
			O_SCL_OUT <= 1'b0;
			O_SCL_OE <= 1'b0;
			O_SDA_OUT <= 1'b0;
			O_SDA_OE <= 1'b0;
			O_STATUS <= `ST_IDLE_CODE;
			O_DATA <= `DATA_RESET;
			O_MASTER_RX <= 1'b0;
		end else if (I_CE) begin
			// software side; a flag set below overrides a clear here
			if (I_CTRL_WR) begin
				ack_en_reg <= I_CTRL_WDATA[`CTRL_ACK_EN];
				start_req_reg <= I_CTRL_WDATA[`CTRL_START];
				stop_req_reg <= I_CTRL_WDATA[`CTRL_STOP];
				enable_reg <= I_CTRL_WDATA[`CTRL_ENABLE];
				if (I_CTRL_WDATA[`CTRL_FLAG])
					flag_reg <= 1'b0;
			end
			if (I_DATA_WR) begin
				if (flag_reg) begin
					O_DATA <= I_DATA_WDATA;
					wc_reg <= 1'b0;
				end else begin
					wc_reg <= 1'b1;
				end
			end
			qcnt_reg <= tick ? qcnt_reg : qcnt_reg + 16'h0001;

			case (state_reg)
			S_IDLE: begin
				O_SCL_OE <= 1'b0;
				O_SDA_OE <= 1'b0;
				if (!flag_reg && enable_reg && start_req_reg)
					state_reg <= S_WAIT_FREE;
			end
			S_WAIT_FREE: begin
				qcnt_reg <= 16'h0000;
				if (!O_BUS_BUSY && scl_s2_reg && sda_s2_reg) begin
					state_reg <= S_START;
					phase_reg <= 2'h1;
					rep_reg <= 1'b0;
				end
			end
			S_START: begin
				case (phase_reg)
				2'h0: begin
					// repeated start: release data and clock together on the same tick
					if (tick) begin
						O_SDA_OE <= 1'b0;
						O_SCL_OE <= 1'b0;
						phase_reg <= 2'h1;
						qcnt_reg <= 16'h0000;
					end
				end
				2'h1: begin
					if (tick && scl_s2_reg) begin
						O_SDA_OE <= 1'b1;
						phase_reg <= 2'h2;
						qcnt_reg <= 16'h0000;
					end
				end
				default: begin
					if (tick) begin
						O_SCL_OE <= 1'b1;
						owner_reg <= 1'b1;
						first_reg <= 1'b1;
						code_reg <= rep_reg ? `ST_RSTART_SENT : `ST_START_SENT;
						state_reg <= S_REPORT;
					end
				end
				endcase
			end
			S_BIT: begin
				case (phase_reg)
				2'h0: begin
					if (tick) begin
						// ninth bit released for the acknowledge; a one is released
						O_SDA_OE <= (bitcnt_reg == `BYTE_LAST_BIT) ? 1'b0 : !shift_reg[7];
						phase_reg <= 2'h1;
						qcnt_reg <= 16'h0000;
					end
				end
				2'h1: begin
					if (tick) begin
						O_SCL_OE <= 1'b0;
						phase_reg <= 2'h2;
						qcnt_reg <= 16'h0000;
					end
				end
				2'h2: begin
					if (tick && scl_s2_reg) begin
						qcnt_reg <= 16'h0000;
						ack_reg <= !sda_s2_reg;
						if (bitcnt_reg != `BYTE_LAST_BIT && !O_SDA_OE && !sda_s2_reg) begin
							// another master drove low: back off
							O_SDA_OE <= 1'b0;
							owner_reg <= 1'b0;
							code_reg <= `ST_ARB_LOST;
							state_reg <= S_REPORT;
						end else begin
							phase_reg <= 2'h3;
						end
					end
				end
				default: begin
					if (tick) begin
						O_SCL_OE <= 1'b1;
						qcnt_reg <= 16'h0000;
						if (bitcnt_reg == `BYTE_LAST_BIT) begin
							code_reg <= byte_code(first_reg, addr_rd_reg, ack_reg);
							if (first_reg)
								O_MASTER_RX <= addr_rd_reg;
							first_reg <= 1'b0;
							state_reg <= S_REPORT;
						end else begin
							bitcnt_reg <= bitcnt_reg + 4'h1;
							shift_reg <= {shift_reg[6:0], 1'b0};
							phase_reg <= 2'h0;
						end
					end
				end
				endcase
			end
			S_STOP: begin
				case (phase_reg)
				2'h0: begin
					if (tick) begin
						O_SDA_OE <= 1'b1;
						phase_reg <= 2'h1;
						qcnt_reg <= 16'h0000;
					end
				end
				2'h1: begin
					if (tick) begin
						O_SCL_OE <= 1'b0;
						phase_reg <= 2'h2;
						qcnt_reg <= 16'h0000;
					end
				end
				2'h2: begin
					if (tick && scl_s2_reg) begin
						O_SDA_OE <= 1'b0;
						phase_reg <= 2'h3;
						qcnt_reg <= 16'h0000;
					end
				end
				default: begin
					if (tick) begin
						// no flag after stop
						stop_req_reg <= 1'b0;
						owner_reg <= 1'b0;
						O_MASTER_RX <= 1'b0;
						state_reg <= start_req_reg ? S_WAIT_FREE : S_IDLE;
					end
				end
				endcase
			end
			S_REPORT: begin
				if (evt_ready) begin
					flag_reg <= 1'b1;
					O_STATUS <= code_reg;
					state_reg <= S_HOLD;
				end
			end
			S_HOLD: begin
				// clock stays low while owned and flagged
				O_SCL_OE <= owner_reg;
				qcnt_reg <= 16'h0000;
				phase_reg <= 2'h0;
				if (!flag_reg) begin
					if (!owner_reg)
						state_reg <= start_req_reg ? S_WAIT_FREE : S_IDLE;
					else if (stop_req_reg)
						state_reg <= S_STOP;
					else if (start_req_reg) begin
						rep_reg <= 1'b1;
						state_reg <= S_START;
					end else begin
						shift_reg <= O_DATA;
						if (first_reg)
							addr_rd_reg <= O_DATA[0];
						bitcnt_reg <= 4'h0;
						state_reg <= S_BIT;
					end
				end
			end
			default: state_reg <= S_IDLE;
			endcase

			if (!enable_reg) begin
				state_reg <= S_IDLE;
				owner_reg <= 1'b0;
				O_SCL_OE <= 1'b0;
				O_SDA_OE <= 1'b0;
			end
		end
	end

endmodule // two_wire_master_transmitter
